// ===== design/amio_top.sv
// per-axis motion i/o supervision, interlock and apb register file
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module amio_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] origin_input,
  input wire logic [3:0] plus_limit_input,
  input wire logic [3:0] minus_limit_input,
  input wire logic [3:0] slow_down_input,
  input wire logic [3:0] position_settled_flag,
  input wire logic [3:0] driver_alarm_input,
  input wire logic [3:0] driver_ready_input,
  input wire logic [3:0] gp_input,
  input wire logic emergency_stop_input,
  input wire logic [3:0] step_request,
  input wire logic [3:0] heading_request,
  input wire logic [127:0] encoder_count,
  output logic [3:0] step_pulse_line,
  output logic [3:0] heading_level_output,
  output logic [3:0] slow_speed_request,
  output logic [3:0] deviation_clear_output,
  output logic [3:0] servo_on_output,
  output logic [3:0] compare_pulse_output,
  output logic [3:0] gp_output,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] apply_pol(input logic [3:0] raw, input logic inv);
    apply_pol = inv ? ~raw : raw;
  endfunction

  function automatic logic [31:0] axis_word(input logic [127:0] v, input int idx);
    axis_word = v[idx*amio_pkg::CW +: amio_pkg::CW];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for every status input pin; step_request and heading_request are used unsynchronised
  localparam int SW = 33;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  wire [SW-1:0] pin_bus = {emergency_stop_input, gp_input, driver_ready_input,
    driver_alarm_input, position_settled_flag, slow_down_input, minus_limit_input,
    plus_limit_input, origin_input};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_bus;
      sync2_r <= sync1_r;
    end
  end

  wire [3:0] org_s = sync2_r[3:0];
  wire [3:0] pel_s = sync2_r[7:4];
  wire [3:0] mel_s = sync2_r[11:8];
  wire [3:0] sdl_s = sync2_r[15:12];
  wire [3:0] inp_s = sync2_r[19:16];
  wire [3:0] alm_s = sync2_r[23:20];
  wire [3:0] rdy_s = sync2_r[27:24];
  wire [3:0] gpi_s = sync2_r[31:28];
  wire emg_raw_s = sync2_r[32];

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_r;
  logic [7:0] out_r;
  logic [amio_pkg::IRQ_W-1:0] irq_stat_r;
  logic [amio_pkg::IRQ_W-1:0] irq_mask_r;
  logic [15:0] clr_len_r;
  logic [31:0] cmp_val_r [amio_pkg::NAX];
  logic [31:0] latch_val_r [amio_pkg::NAX];
  logic sw_stop_r;
  wire wr_en = psel & penable & pwrite;
  wire [3:0] home_mode = ctrl_r[amio_pkg::CTRL_HOME_LSB +: 4];
  wire [3:0] ltc_sel = ctrl_r[amio_pkg::CTRL_LTC_SEL_LSB +: 4];
  wire cmp_idle_hi = ctrl_r[amio_pkg::CTRL_CMP_IDLE_HI];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= amio_pkg::CTRL_RESET;
      out_r <= '0;
      irq_mask_r <= '0;
      clr_len_r <= amio_pkg::CLR_LEN_RESET;
    end else if (wr_en) begin
      case (paddr)
        amio_pkg::REG_CTRL: ctrl_r <= {21'h00_0000, pwdata[10:0]};
        amio_pkg::REG_OUT: out_r <= pwdata[7:0];
        amio_pkg::REG_IRQ_MASK: irq_mask_r <= pwdata[amio_pkg::IRQ_W-1:0];
        amio_pkg::REG_CLR_LEN: clr_len_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        cmp_val_r[i] <= '0;
      end
    end else if (wr_en && paddr[7:4] == amio_pkg::REG_CMP_BASE[7:4] && paddr[1:0] == 2'b00) begin
      cmp_val_r[paddr[3:2]] <= pwdata;
    end
  end

  // software emergency stop is a write-one strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_stop_r <= 1'b0;
    end else begin
      sw_stop_r <= wr_en && paddr == amio_pkg::REG_SW_STOP && pwdata[0];
    end
  end

  assign servo_on_output = out_r[amio_pkg::OUT_SERVO_ON_OUTPUT_LSB +: 4];
  assign gp_output = out_r[amio_pkg::OUT_GPO_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // origin spike filter: output follows only after the input stays stable
  localparam int OFW = $clog2(amio_pkg::ORG_FILT_CYC + 1);
  localparam logic [OFW-1:0] ORG_FILT_MAX = OFW'(amio_pkg::ORG_FILT_CYC);
  logic [OFW-1:0] org_cnt_r [amio_pkg::NAX];
  logic [3:0] org_f_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_f_r <= '0;
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        org_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        if (org_s[i] == org_f_r[i]) begin
          org_cnt_r[i] <= '0;
        end else if (org_cnt_r[i] == ORG_FILT_MAX - OFW'(1)) begin
          org_f_r[i] <= org_s[i];
          org_cnt_r[i] <= '0;
        end else begin
          org_cnt_r[i] <= org_cnt_r[i] + OFW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interlock and pulse gating
  wire [3:0] pel_a = apply_pol(pel_s, ctrl_r[amio_pkg::CTRL_LIM_NC]);
  wire [3:0] mel_a = apply_pol(mel_s, ctrl_r[amio_pkg::CTRL_LIM_NC]);
  wire emg_a = emg_raw_s ^ ctrl_r[amio_pkg::CTRL_EMG_NC];
  wire [3:0] home_blk = home_mode & org_f_r;
  // a limit blocks only the direction that runs into it
  wire [3:0] lim_blk = (heading_request & pel_a) | (~heading_request & mel_a);
  wire [3:0] axis_ok = ~alm_s & ~home_blk & ~lim_blk & {4{~emg_a}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pulse_line <= '0;
      heading_level_output <= '0;
      slow_speed_request <= '0;
    end else begin
      step_pulse_line <= step_request & axis_ok;
      // heading is held while stopped rather than following the request
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        if (axis_ok[i]) begin
          heading_level_output[i] <= heading_request[i];
        end
      end
      slow_speed_request <= sdl_s & ~ltc_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event edge detection
  logic [3:0] org_d_r;
  logic [3:0] lim_d_r;
  logic [3:0] alm_d_r;
  logic [3:0] sdl_d_r;
  logic emg_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_d_r <= '0;
      lim_d_r <= '0;
      alm_d_r <= '0;
      sdl_d_r <= '0;
      emg_d_r <= 1'b0;
    end else begin
      org_d_r <= home_blk;
      lim_d_r <= pel_a | mel_a;
      alm_d_r <= alm_s;
      sdl_d_r <= sdl_s;
      emg_d_r <= emg_a;
    end
  end

  wire [3:0] home_done_ev = home_blk & ~org_d_r;
  wire [3:0] lim_ev = (pel_a | mel_a) & ~lim_d_r;
  wire [3:0] alm_ev = alm_s & ~alm_d_r;
  wire [3:0] ltc_ev = sdl_s & ~sdl_d_r & ltc_sel;
  wire emg_ev = emg_a & ~emg_d_r;
  wire [3:0] clr_trig = home_done_ev | lim_ev | alm_ev | {4{emg_ev | sw_stop_r}};

  ////////////////////////////////////////////////////////////////////////////////
  // deviation clear pulse per axis
  amio_pkg::amio_clr_state_t clr_st_r [amio_pkg::NAX];
  logic [15:0] clr_cnt_r [amio_pkg::NAX];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        clr_st_r[i] <= amio_pkg::AMIO_CLR_IDLE;
        clr_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        case (clr_st_r[i])
          amio_pkg::AMIO_CLR_IDLE: begin
            if (clr_trig[i] && clr_len_r != 16'h0000) begin
              clr_st_r[i] <= amio_pkg::AMIO_CLR_ACTIVE;
              clr_cnt_r[i] <= clr_len_r - 16'h0001;
            end
          end
          amio_pkg::AMIO_CLR_ACTIVE: begin
            // a new cause restarts the full length
            if (clr_trig[i]) begin
              clr_cnt_r[i] <= clr_len_r - 16'h0001;
            end else if (clr_cnt_r[i] == 16'h0000) begin
              clr_st_r[i] <= amio_pkg::AMIO_CLR_IDLE;
            end else begin
              clr_cnt_r[i] <= clr_cnt_r[i] - 16'h0001;
            end
          end
          default: clr_st_r[i] <= amio_pkg::AMIO_CLR_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < amio_pkg::NAX; i++) begin
      deviation_clear_output[i] = clr_st_r[i] == amio_pkg::AMIO_CLR_ACTIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // position latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        latch_val_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        if (ltc_ev[i]) begin
          latch_val_r[i] <= axis_word(encoder_count, i);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare channels: fire once on reaching the preset, fixed pulse width
  localparam int CPW = $clog2(amio_pkg::CMP_PULSE_CYC + 1);
  localparam logic [CPW-1:0] CMP_LEN = CPW'(amio_pkg::CMP_PULSE_CYC);
  logic [3:0] cmp_hit_d_r;
  logic [CPW-1:0] cmp_cnt_r [amio_pkg::NAX];
  logic [3:0] cmp_act;
  logic [3:0] cmp_hit;
  logic [3:0] cmp_out_r;

  always_comb begin
    for (int i = 0; i < amio_pkg::NAX; i++) begin
      cmp_hit[i] = axis_word(encoder_count, i) == cmp_val_r[i];
      cmp_act[i] = cmp_cnt_r[i] != '0;
    end
  end

  wire [3:0] cmp_ev = cmp_hit & ~cmp_hit_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_hit_d_r <= 4'hf; // counts and presets both start at zero: no false hit
      cmp_out_r <= 4'hf;
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        cmp_cnt_r[i] <= '0;
      end
    end else begin
      cmp_hit_d_r <= cmp_hit;
      for (int i = 0; i < amio_pkg::NAX; i++) begin
        if (cmp_ev[i]) begin
          cmp_cnt_r[i] <= CMP_LEN;
        end else if (cmp_act[i]) begin
          cmp_cnt_r[i] <= cmp_cnt_r[i] - CPW'(1);
        end
      end
      cmp_out_r <= cmp_idle_hi ? ~cmp_act : cmp_act;
    end
  end

  assign compare_pulse_output = cmp_out_r;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  wire [amio_pkg::IRQ_W-1:0] irq_set = {emg_ev, lim_ev, alm_ev, cmp_ev, ltc_ev};
  wire [amio_pkg::IRQ_W-1:0] irq_clr =
    (wr_en && paddr == amio_pkg::REG_IRQ_STAT) ? pwdata[amio_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_r & ~irq_clr | irq_set) & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb read path, data captured in the setup cycle so access is zero-wait
  logic [31:0] rd_nxt;
  logic rd_ok;

  always_comb begin
    rd_nxt = '0;
    rd_ok = 1'b1;
    case (paddr)
      amio_pkg::REG_CTRL: rd_nxt = ctrl_r;
      amio_pkg::REG_OUT: rd_nxt = {24'h00_0000, out_r};
      amio_pkg::REG_PINS: rd_nxt = {gpi_s, rdy_s, inp_s, alm_s, sdl_s, mel_a, pel_a,
        org_f_r};
      amio_pkg::REG_IRQ_STAT: rd_nxt = {15'h0000, irq_stat_r};
      amio_pkg::REG_IRQ_MASK: rd_nxt = {15'h0000, irq_mask_r};
      amio_pkg::REG_CLR_LEN: rd_nxt = {16'h0000, clr_len_r};
      amio_pkg::REG_STATE: rd_nxt = {15'h0000, emg_a, deviation_clear_output, slow_speed_request,
        lim_blk, axis_ok};
      amio_pkg::REG_SW_STOP: rd_nxt = '0;
      default: begin
        if (paddr[1:0] != 2'b00) begin
          rd_ok = 1'b0;
        end else if (paddr[7:4] == amio_pkg::REG_CMP_BASE[7:4]) begin
          rd_nxt = cmp_val_r[paddr[3:2]];
        end else if (paddr[7:4] == amio_pkg::REG_LATCH_BASE[7:4]) begin
          rd_nxt = latch_val_r[paddr[3:2]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  logic err_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      // latch values are read-only, so writes to them are errors too
      err_r <= !rd_ok || (pwrite && paddr[7:4] == amio_pkg::REG_LATCH_BASE[7:4]);
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;
endmodule

// ===== design/amio_pkg.sv
// constants shared by the axis motion i/o supervision block
package amio_pkg;
  localparam int NAX = 4;
  localparam int CW = 32;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OUT = 8'h04;
  localparam logic [7:0] REG_PINS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_CLR_LEN = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;
  localparam logic [7:0] REG_SW_STOP = 8'h1c;
  localparam logic [7:0] REG_CMP_BASE = 8'h20;
  localparam logic [7:0] REG_LATCH_BASE = 8'h30;
  // control register fields
  localparam int CTRL_HOME_LSB = 0;
  localparam int CTRL_LTC_SEL_LSB = 4;
  localparam int CTRL_LIM_NC = 8;
  localparam int CTRL_EMG_NC = 9;
  localparam int CTRL_CMP_IDLE_HI = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_04f0;
  // output register fields
  localparam int OUT_SERVO_ON_OUTPUT_LSB = 0;
  localparam int OUT_GPO_LSB = 4;
  // interrupt status fields
  localparam int IRQ_LATCH_LSB = 0;
  localparam int IRQ_CMP_LSB = 4;
  localparam int IRQ_ALM_LSB = 8;
  localparam int IRQ_LIM_LSB = 12;
  localparam int IRQ_EMG = 16;
  localparam int IRQ_W = 17;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int ORG_FILT_NS = 1000;
  localparam int ORG_FILT_CYC = (ORG_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int CMP_PULSE_NS = 100;
  localparam int CMP_PULSE_CYC = (CMP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CLR_LEN_RESET = 16'h0064;
  typedef enum logic [1:0] {
    AMIO_CLR_IDLE = 2'b00,
    AMIO_CLR_ACTIVE = 2'b01
  } amio_clr_state_t;
endpackage

// ===== bench/amio_monitor.sv
// port-level assertions for the axis motion i/o block
`timescale 1ns/1ps
module amio_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [3:0] heading_request,
  input wire logic [3:0] origin_input,
  input wire logic [3:0] plus_limit_input,
  input wire logic [3:0] driver_alarm_input,
  input wire logic emergency_stop_input,
  input wire logic [3:0] step_pulse_line,
  input wire logic [3:0] deviation_clear_output,
  input wire logic [3:0] servo_on_output,
  input wire logic [3:0] gp_output,
  input wire logic [3:0] compare_pulse_output
);
  logic [31:0] ctrl_r;
  logic [7:0] org_cnt_r;
  logic [3:0] lim_act;
  logic emg_act;
  logic wr_go;
  assign wr_go = psel && penable && pwrite && pready;
  // polarity mirrored from bus writes, the checker cannot see the register
  assign lim_act = plus_limit_input ^ {4{ctrl_r[amio_pkg::CTRL_LIM_NC]}};
  assign emg_act = emergency_stop_input ^ ctrl_r[amio_pkg::CTRL_EMG_NC];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= amio_pkg::CTRL_RESET;
    end else if (wr_go && paddr == amio_pkg::REG_CTRL) begin
      ctrl_r <= pwdata;
    end
  end
  // long stable origin, well past synchroniser and filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_cnt_r <= 8'h00;
    end else if (!origin_input[0]) begin
      org_cnt_r <= 8'h00;
    end else if (org_cnt_r != 8'hff) begin
      org_cnt_r <= org_cnt_r + 8'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////
  property p_home;
    ctrl_r[0] && org_cnt_r > 8'h70 |=> !step_pulse_line[0];
  endproperty
  a_home: assert property (p_home) else $error("step passed at origin in home mode");
  property p_alarm;
    driver_alarm_input[1] [*4] |-> !step_pulse_line[1];
  endproperty
  a_alarm: assert property (p_alarm) else $error("step passed during alarm");
  property p_emg;
    emg_act [*4] |-> step_pulse_line == 4'h0;
  endproperty
  a_emg: assert property (p_emg) else $error("step passed during emergency");
  property p_lim;
    lim_act[2] [*4] ##0 heading_request[2] |=> !step_pulse_line[2];
  endproperty
  a_lim: assert property (p_lim) else $error("step passed toward plus limit");
  property p_servo_on_output;
    wr_go && paddr == amio_pkg::REG_OUT |=> servo_on_output == $past(pwdata[3:0]);
  endproperty
  a_servo_on_output: assert property (p_servo_on_output) else $error("servo on not updated");
  property p_gpo;
    wr_go && paddr == amio_pkg::REG_OUT |=> gp_output == $past(pwdata[7:4]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("gp output not updated");
  property p_cmp_idle;
    $rose(presetn) |-> compare_pulse_output == 4'hf;
  endproperty
  a_cmp_idle: assert property (p_cmp_idle) else $error("compare not idle high");
  property p_clr_lim;
    !lim_act[2] ##1 lim_act[2] [*4] |-> ##[0:3] deviation_clear_output[2];
  endproperty
  a_clr_lim: assert property (p_clr_lim) else $error("no clear on limit");
endmodule
bind amio_top amio_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .heading_request, .origin_input, .plus_limit_input,
  .driver_alarm_input, .emergency_stop_input, .step_pulse_line, .deviation_clear_output,
  .servo_on_output, .gp_output, .compare_pulse_output);

// ===== bench/amio_drive_model.sv
// behavioural servo drive and encoder on the far side of the block
`timescale 1ns/1ps
module amio_drive_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [3:0] alarm_cmd,
  input wire logic [3:0] ready_cmd,
  output logic [127:0] encoder_count,
  output logic [3:0] driver_alarm_input,
  output logic [3:0] position_settled_flag,
  output logic [3:0] driver_ready_input
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encoder_count <= 128'h0;
      driver_alarm_input <= 4'h0;
      position_settled_flag <= 4'hf;
      driver_ready_input <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (run) begin
          encoder_count[32*i +: 32] <= encoder_count[32*i +: 32] + 32'(i + 1);
        end
      end
      // zero deviation only while the axis stands still
      position_settled_flag <= {4{!run}};
      driver_alarm_input <= alarm_cmd;
      driver_ready_input <= ready_cmd;
    end
  end
endmodule

// ===== bench/axis_motion_io_interlock_tb.sv
// self-checking bench for the axis motion i/o interlock block
`timescale 1ns/1ps
module axis_motion_io_interlock_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, run, irq;
  logic emergency_stop_input;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] origin_input, plus_limit_input, minus_limit_input, slow_down_input;
  logic [3:0] gp_input, position_settled_flag, driver_alarm_input, driver_ready_input;
  logic [3:0] alarm_cmd, ready_cmd, step_request, heading_request, step_pulse_line;
  logic [3:0] heading_level_output, slow_speed_request, deviation_clear_output;
  logic [3:0] servo_on_output, compare_pulse_output, gp_output;
  logic [127:0] encoder_count;
  int fail_count, checked, len;
  amio_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .origin_input, .plus_limit_input, .minus_limit_input,
    .slow_down_input, .position_settled_flag, .driver_alarm_input, .driver_ready_input,
    .gp_input, .emergency_stop_input, .step_request, .heading_request, .encoder_count,
    .step_pulse_line, .heading_level_output, .slow_speed_request, .deviation_clear_output,
    .servo_on_output, .compare_pulse_output, .gp_output, .irq);
  amio_drive_model u_drive (.pclk, .presetn, .run, .alarm_cmd, .ready_cmd, .encoder_count,
    .driver_alarm_input, .position_settled_flag, .driver_ready_input);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // registered outputs are read one edge after they change, never racing
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stp(input int ax, input logic hd, input logic exp);
    heading_request[ax] <= hd;
    step_request[ax] <= 1'b1;
    @(posedge pclk);
    step_request[ax] <= 1'b0;
    @(posedge pclk);
    chk(32'(step_pulse_line[ax]), 32'(exp));
    if (exp) begin
      chk(32'(heading_level_output[ax]), 32'(hd));
    end
  endtask
  // cycles at level v within a 40-cycle window, one pulse expected
  task automatic run_len(input logic cmp, input int ax, input logic v);
    len = 0;
    repeat (40) begin
      @(posedge pclk);
      if ((cmp ? compare_pulse_output[ax] : deviation_clear_output[ax]) === v) len++;
    end
  endtask
  ////////////////////////////////////////////////
  task automatic t_regs;
    chk(32'(compare_pulse_output), 32'h0000_000f);
    apb(amio_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(q, amio_pkg::CTRL_RESET);
    apb(amio_pkg::REG_CLR_LEN, 1'b0, 32'h0);
    chk(q, 32'h0000_0064);
    apb(8'h40, 1'b0, 32'h0);
    chk(32'(last_err), 32'h0000_0001);
  endtask
  task automatic t_out;
    apb(amio_pkg::REG_OUT, 1'b1, 32'h0000_00a5);
    chk(32'(servo_on_output), 32'h0000_0005);
    chk(32'(gp_output), 32'h0000_000a);
  endtask
  task automatic t_pins;
    gp_input <= 4'h9;
    ready_cmd <= 4'h6;
    run <= 1'b0;
    waitn(5);
    apb(amio_pkg::REG_PINS, 1'b0, 32'h0);
    chk(32'(q[31:28]), 32'h0000_0009);
    chk(32'(q[27:24]), 32'h0000_0006);
    chk(32'(q[23:20]), 32'h0000_000f);
    run <= 1'b1;
  endtask
  task automatic t_alarm;
    apb(amio_pkg::REG_CLR_LEN, 1'b1, 32'h0000_0005);
    apb(amio_pkg::REG_IRQ_MASK, 1'b1, 32'h0);
    alarm_cmd[1] <= 1'b1;
    run_len(1'b0, 1, 1'b1);
    chk(32'(len), 32'h0000_0005);
    chk(32'(irq), 32'h0);
    stp(1, 1'b1, 1'b0);
    apb(amio_pkg::REG_IRQ_MASK, 1'b1, 32'h0000_0200);
    waitn(1);
    chk(32'(irq), 32'h0000_0001);
    alarm_cmd[1] <= 1'b0;
    waitn(4);
    apb(amio_pkg::REG_IRQ_STAT, 1'b1, 32'h0000_0200);
    waitn(1);
    chk(32'(irq), 32'h0);
    stp(1, 1'b1, 1'b1);
  endtask
  task automatic t_limit;
    plus_limit_input[2] <= 1'b1;
    waitn(4);
    stp(2, 1'b1, 1'b0);
    stp(2, 1'b0, 1'b1);
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_05f0);
    stp(2, 1'b1, 1'b1);
    stp(3, 1'b1, 1'b0);
    plus_limit_input[2] <= 1'b0;
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_04f0);
    minus_limit_input[0] <= 1'b1;
    waitn(4);
    stp(0, 1'b0, 1'b0);
    stp(0, 1'b1, 1'b1);
    minus_limit_input[0] <= 1'b0;
  endtask
  task automatic t_emg;
    emergency_stop_input <= 1'b1;
    waitn(4);
    stp(0, 1'b1, 1'b0);
    emergency_stop_input <= 1'b0;
    waitn(4);
    stp(0, 1'b1, 1'b1);
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_06f0);
    stp(1, 1'b0, 1'b0);
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_04f0);
    waitn(10);
    apb(amio_pkg::REG_SW_STOP, 1'b1, 32'h0000_0001);
    run_len(1'b0, 3, 1'b1);
    chk(32'(len), 32'h0000_0005);
  endtask
  task automatic t_home;
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_04f1);
    origin_input[0] <= 1'b1;
    waitn(5);
    origin_input[0] <= 1'b0;
    waitn(4);
    stp(0, 1'b1, 1'b1);
    origin_input[0] <= 1'b1;
    waitn(120);
    stp(0, 1'b1, 1'b0);
    origin_input[0] <= 1'b0;
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_04f0);
    stp(0, 1'b1, 1'b1);
  endtask
  task automatic t_latch;
    logic [31:0] c;
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_04d0);
    c = encoder_count[31:0];
    slow_down_input <= 4'h3;
    waitn(4);
    chk(32'(slow_speed_request), 32'h0000_0002);
    apb(amio_pkg::REG_LATCH_BASE, 1'b0, 32'h0);
    chk(32'(q - c <= 32'h0000_0008), 32'h0000_0001);
    slow_down_input <= 4'h0;
  endtask
  task automatic t_cmp;
    apb(amio_pkg::REG_CMP_BASE, 1'b1, encoder_count[31:0] + 32'h0000_0014);
    run_len(1'b1, 0, 1'b0);
    chk(32'(len), 32'h0000_000a);
    apb(amio_pkg::REG_CTRL, 1'b1, 32'h0000_00f0);
    waitn(1);
    chk(32'(compare_pulse_output), 32'h0);
    apb(amio_pkg::REG_CMP_BASE, 1'b1, encoder_count[31:0] + 32'h0000_0014);
    run_len(1'b1, 0, 1'b1);
    chk(32'(len), 32'h0000_000a);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, emergency_stop_input} = '0;
    {origin_input, plus_limit_input, minus_limit_input, slow_down_input} = '0;
    {gp_input, alarm_cmd, ready_cmd, step_request, heading_request} = '0;
    run = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_out();
    t_pins();
    t_alarm();
    t_limit();
    t_emg();
    t_home();
    t_latch();
    t_cmp();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule
